/* verilog/uefc_flow.sv */
// Per-channel enhanced feature and flow-control logic with an AHB-Lite register slave.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module uefc_flow
    import uefc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cts_n,
    input wire logic dsr_n,
    output logic rts_n,
    output logic dtr_n,
    output logic tx_hold,
    input wire logic [5:0] rx_fill,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    output logic rx_store,
    output logic [7:0] ctl_char,
    output logic ctl_valid,
    input wire logic ctl_ready,
    output logic [7:0] interrupt_enable_reg,
    output logic [7:0] fifo_control_reg,
    output logic [7:0] msr_ctl,
    output logic rx_trig_irq,
    output logic [7:0] isr_enh
);
    logic [7:0] efc, modem_control_reg, xon_char_first, xon_char_second, xoff_char_first, xoff_char_second, fcs, trig;
    logic ph_wr, ph_rd;
    logic [7:0] ph_addr;
    logic cts_m, cts_s, dsr_m, dsr_s;
    logic rx_flow_hi, rx_seq_on, rx_seq_off;
    uefc_tx_t tx_state;
    logic tx_is_xon;

    // Software may only touch the enhanced bits while the unlock bit is set.
    function automatic logic [7:0] gated(input logic [7:0] cur, input logic [7:0] wr,
                                         input logic [7:0] mask, input logic en);
        gated = en ? wr : ((cur & mask) | (wr & ~mask));
    endfunction : gated

    wire take = hsel && hready && htrans == HTRANS_NONSEQ;
    wire wr_now = ph_wr;
    wire [7:0] wd = hwdata[7:0];
    wire enh_on = efc[EFC_ENH];
    wire [1:0] tx_sel = efc[3:2];
    wire [1:0] rx_sel = efc[1:0];
    wire sw_off = efc[3:0] == 4'h0;
    wire rd_fcs = ph_rd && ph_addr == ADDR_FCS;
    wire flow_in = modem_control_reg[MCR_SEL] ? dsr_s : cts_s;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= RST_BYTE;
        end
        else
        begin
            ph_wr <= take && hwrite;
            ph_rd <= take && !hwrite;
            ph_addr <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cts_m <= 1'b1;
            cts_s <= 1'b1;
            dsr_m <= 1'b1;
            dsr_s <= 1'b1;
        end
        else
        begin
            cts_m <= cts_n;
            cts_s <= cts_m;
            dsr_m <= dsr_n;
            dsr_s <= dsr_m;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            efc <= RST_BYTE;
            modem_control_reg <= RST_BYTE;
            interrupt_enable_reg <= RST_BYTE;
            fifo_control_reg <= RST_BYTE;
            msr_ctl <= RST_BYTE;
            xon_char_first <= RST_BYTE;
            xon_char_second <= RST_BYTE;
            xoff_char_first <= RST_BYTE;
            xoff_char_second <= RST_BYTE;
            trig <= RST_BYTE;
        end
        else if (wr_now)
        begin
            case (ph_addr)
                ADDR_EFC: efc <= wd;
                ADDR_MCR: modem_control_reg <= gated(modem_control_reg, wd, MASK_MCR, enh_on);
                ADDR_IER: interrupt_enable_reg <= gated(interrupt_enable_reg, wd, MASK_IER, enh_on);
                ADDR_FCR: fifo_control_reg <= gated(fifo_control_reg, wd, MASK_FCR, enh_on);
                ADDR_MSR: msr_ctl <= gated(msr_ctl, wd, MASK_MSR, enh_on);
                ADDR_XON_CHAR_FIRST: xon_char_first <= wd;
                ADDR_XON_CHAR_SECOND: xon_char_second <= wd;
                ADDR_XOFF_CHAR_FIRST: xoff_char_first <= wd;
                ADDR_XOFF_CHAR_SECOND: xoff_char_second <= wd;
                ADDR_TRIG: trig <= wd;
                default: ;
            endcase
        end
    end

    assign tx_hold = efc[EFC_AUTO_CTS] && flow_in;

    // Hysteresis: trig[7:4]*4 is the upper level, trig[3:0]*2 is the lower level.
    wire [5:0] upper = {trig[7:4], 2'b00};
    wire [5:0] lower = {1'b0, trig[3:0], 1'b0};
    assign rx_trig_irq = rx_fill >= upper && trig != RST_BYTE;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rx_flow_hi <= 1'b0;
        else if (!efc[EFC_AUTO_RTS])
            rx_flow_hi <= 1'b0;
        else if (rx_fill >= upper)
            rx_flow_hi <= 1'b1;
        else if (rx_fill < lower)
            rx_flow_hi <= 1'b0;
    end

    wire auto_out = efc[EFC_AUTO_RTS] && rx_flow_hi;
    assign rts_n = !modem_control_reg[MCR_RTS] || (auto_out && !modem_control_reg[MCR_SEL]);
    assign dtr_n = !modem_control_reg[MCR_DTR] || (auto_out && modem_control_reg[MCR_SEL]);

    wire dual_rx = rx_sel == SEL_BOTH && (tx_sel == SEL_BOTH || tx_sel == SEL_NONE);
    wire any_rx = rx_sel == SEL_BOTH && !dual_rx;
    wire m_on1 = rx_char == xon_char_first;
    wire m_on2 = rx_char == xon_char_second;
    wire m_off1 = rx_char == xoff_char_first;
    wire m_off2 = rx_char == xoff_char_second;
    wire got_on = rx_valid && ((rx_sel == SEL_FIRST && m_on1) || (rx_sel == SEL_SECOND && m_on2)
                  || (any_rx && (m_on1 || m_on2)) || (dual_rx && rx_seq_on && m_on2));
    wire got_off = rx_valid && ((rx_sel == SEL_FIRST && m_off1)
                   || (rx_sel == SEL_SECOND && m_off2)
                   || (any_rx && (m_off1 || m_off2)) || (dual_rx && rx_seq_off && m_off2));
    wire special = rx_valid && efc[EFC_SPECIAL] && m_off2;
    assign rx_store = rx_valid && !(special && rx_sel == SEL_SECOND);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_seq_on <= 1'b0;
            rx_seq_off <= 1'b0;
            isr_enh <= RST_BYTE;
        end
        else
        begin
            if (rx_valid)
            begin
                rx_seq_on <= m_on1;
                rx_seq_off <= m_off1;
            end
            if (wr_now && ph_addr == ADDR_ISR)
                isr_enh <= gated(isr_enh, wd, MASK_ISR, enh_on);
            if (special)
                isr_enh[ISR_SPECIAL] <= 1'b1;
            if (got_off && rx_sel == SEL_SECOND && efc[EFC_SPECIAL])
                isr_enh[ISR_XOFF] <= 1'b1;
        end
    end

    wire tx_cmd = wr_now && ph_addr == ADDR_TXCMD && tx_sel != SEL_NONE;
    wire [7:0] ch_first = wd[0] ? xon_char_first : xoff_char_first;
    wire [7:0] ch_second = wd[0] ? xon_char_second : xoff_char_second;
    wire tx_done = tx_state == UEFC_TX_SEND && ctl_ready && tx_sel != SEL_BOTH
                   || tx_state == UEFC_TX_SECOND && ctl_ready;
    assign ctl_valid = tx_state != UEFC_TX_IDLE;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_state <= UEFC_TX_IDLE;
            ctl_char <= RST_BYTE;
            tx_is_xon <= 1'b0;
        end
        else
        begin
            case (tx_state)
                UEFC_TX_IDLE:
                    if (tx_cmd)
                    begin
                        tx_state <= UEFC_TX_SEND;
                        tx_is_xon <= wd[0];
                        ctl_char <= tx_sel == SEL_SECOND ? ch_second : ch_first;
                    end
                UEFC_TX_SEND:
                    if (ctl_ready)
                    begin
                        if (tx_sel == SEL_BOTH)
                        begin
                            tx_state <= UEFC_TX_SECOND;
                            ctl_char <= tx_is_xon ? xon_char_second : xoff_char_second;
                        end
                        else
                            tx_state <= UEFC_TX_IDLE;
                    end
                UEFC_TX_SECOND:
                    if (ctl_ready)
                        tx_state <= UEFC_TX_IDLE;
                default: tx_state <= UEFC_TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fcs <= RST_BYTE;
        else if (sw_off)
            fcs <= RST_BYTE;
        else
        begin
            if (rd_fcs)
                fcs <= RST_BYTE;
            if (tx_done)
            begin
                fcs[FCS_TX_XON] <= tx_is_xon;
                fcs[FCS_TX_XOFF] <= !tx_is_xon;
            end
            if (got_on || got_off)
            begin
                fcs[FCS_RX_XON] <= got_on;
                fcs[FCS_RX_XOFF] <= got_off;
            end
        end
    end

    wire [7:0] rd_byte = ph_addr == ADDR_EFC ? efc :
                         ph_addr == ADDR_FCS ? {4'h0, fcs[3:0]} :
                         ph_addr == ADDR_MCR ? modem_control_reg :
                         ph_addr == ADDR_IER ? interrupt_enable_reg :
                         ph_addr == ADDR_FCR ? fifo_control_reg :
                         ph_addr == ADDR_MSR ? msr_ctl :
                         ph_addr == ADDR_ISR ? isr_enh :
                         ph_addr == ADDR_TRIG ? trig : RST_BYTE;
    assign hrdata = ph_rd ? {24'h000000, rd_byte} : RST_WORD;

    a_tx_hold_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        efc[EFC_AUTO_CTS] && !modem_control_reg[MCR_SEL] && cts_s |-> tx_hold)
        else $error("transmit not held");
    a_rx_flow_up: assert property (@(posedge hclk) disable iff (!hresetn)
        efc[EFC_AUTO_RTS] && rx_fill >= upper |=> rx_flow_hi || !efc[EFC_AUTO_RTS])
        else $error("flow output not raised");
    a_rx_flow_down: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_fill < lower && rx_fill < upper |=> !rx_flow_hi)
        else $error("flow output not released");
    a_xoff_char_second_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        special && rx_sel == SEL_SECOND |-> !rx_store ##1 isr_enh[ISR_SPECIAL])
        else $error("second xoff stored");
    a_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_now && ph_addr == ADDR_IER && !enh_on |=> interrupt_enable_reg[7:5] == $past(interrupt_enable_reg[7:5]))
        else $error("locked bits changed");
    a_status_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        sw_off |=> fcs == RST_BYTE)
        else $error("status not cleared");
    a_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_fcs && !tx_done && !got_on && !got_off |=> fcs == RST_BYTE)
        else $error("status not cleared by read");
    a_dual_seq: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_state == UEFC_TX_SEND && ctl_ready && tx_sel == SEL_BOTH |=> tx_state == UEFC_TX_SECOND)
        else $error("second character skipped");
    a_rx_keep_first: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_valid && rx_sel == SEL_FIRST |-> rx_store)
        else $error("character not stored");
    a_special_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        special |=> isr_enh[ISR_SPECIAL])
        else $error("special flag not set");
    a_plain_out: assert property (@(posedge hclk) disable iff (!hresetn)
        !efc[EFC_AUTO_RTS] |-> rts_n == !modem_control_reg[MCR_RTS] && dtr_n == !modem_control_reg[MCR_DTR])
        else $error("flow output not plain");
    a_either_char: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_valid && any_rx && (m_on1 || m_on2) |-> got_on)
        else $error("single xon not accepted");
    a_tx_status: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_done && !sw_off |=> fcs[FCS_TX_XON] == $past(tx_is_xon)
        && fcs[FCS_TX_XOFF] != $past(tx_is_xon))
        else $error("sent status wrong");
    a_rx_status: assert property (@(posedge hclk) disable iff (!hresetn)
        got_off && !got_on && !sw_off |=> fcs[FCS_RX_XOFF] && !fcs[FCS_RX_XON])
        else $error("received status wrong");
    c_dual_send: cover property (@(posedge hclk) tx_state == UEFC_TX_SECOND && ctl_ready);
    c_xoff_char_second_drop: cover property (@(posedge hclk) special && rx_sel == SEL_SECOND);
    c_rx_xoff: cover property (@(posedge hclk) got_off);
    c_flow_hi: cover property (@(posedge hclk) rx_flow_hi);
endmodule : uefc_flow

/* common/uefc_pkg.sv */
// Package with register map, field positions and encodings of the UART flow-control block.
// How it works
// - Auto flow input high stops transmitter.
// - Modem control bit 2 picks flow input.
// - Bit 2 set: DSR/DTR, clear: CTS/RTS.
// - Upper trigger raises interrupt, drives output high.
// - Below lower trigger drives output low.
// - Bit 2 picks output; else plain output.
// - Special detect matches second Xoff, flags it.
// - Select 10: flow and detect both normal.
// - Select 01: second Xoff dropped, two interrupts.
// - Enhanced bits writable only while enabled.
// - Enable clear locks enhanced bits.
// - Reset clears all enhanced bits.
// - Transmit select follows feature bits 3:2.
// - Dual mode sends two consecutive characters.
// - Receive select follows feature bits 1:0.
// - Rx 11, tx single: either character matches.
// - Rx 11, tx 11/00: sequence only.
// - Reset selects no software flow control.
// - Four character registers are write-only.
// - Status reads zero when flow disabled.
// - Status bits 3/2: last sent Xon/Xoff.
// - Status bits 1/0: last received Xon/Xoff.
// - Reading status clears indicator bits.
package uefc_pkg;
    localparam logic [7:0] ADDR_EFC = 8'h00;
    localparam logic [7:0] ADDR_XON_CHAR_FIRST = 8'h04;
    localparam logic [7:0] ADDR_XON_CHAR_SECOND = 8'h08;
    localparam logic [7:0] ADDR_XOFF_CHAR_FIRST = 8'h0C;
    localparam logic [7:0] ADDR_XOFF_CHAR_SECOND = 8'h10;
    localparam logic [7:0] ADDR_FCS = 8'h14;
    localparam logic [7:0] ADDR_MCR = 8'h18;
    localparam logic [7:0] ADDR_IER = 8'h1C;
    localparam logic [7:0] ADDR_FCR = 8'h20;
    localparam logic [7:0] ADDR_MSR = 8'h24;
    localparam logic [7:0] ADDR_ISR = 8'h28;
    localparam logic [7:0] ADDR_TRIG = 8'h2C;
    localparam logic [7:0] ADDR_TXCMD = 8'h30;
    localparam int EFC_AUTO_CTS = 7;
    localparam int EFC_AUTO_RTS = 6;
    localparam int EFC_SPECIAL = 5;
    localparam int EFC_ENH = 4;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_SEL = 2;
    localparam int ISR_SPECIAL = 4;
    localparam int ISR_XOFF = 5;
    localparam logic [7:0] MASK_IER = 8'hE0;
    localparam logic [7:0] MASK_ISR = 8'h30;
    localparam logic [7:0] MASK_FCR = 8'h30;
    localparam logic [7:0] MASK_MCR = 8'hEC;
    localparam logic [7:0] MASK_MSR = 8'hFC;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] SEL_NONE = 2'b00;
    localparam logic [1:0] SEL_FIRST = 2'b10;
    localparam logic [1:0] SEL_SECOND = 2'b01;
    localparam logic [1:0] SEL_BOTH = 2'b11;
    localparam int FCS_TX_XON = 3;
    localparam int FCS_TX_XOFF = 2;
    localparam int FCS_RX_XON = 1;
    localparam int FCS_RX_XOFF = 0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    typedef enum logic [1:0] {UEFC_TX_IDLE, UEFC_TX_SEND, UEFC_TX_SECOND} uefc_tx_t;
endpackage : uefc_pkg

/* sim/uefc_remote.sv */
// Remote serial device model: modem inputs, received characters and a control-character sink.
`timescale 1ns/1ps
module uefc_remote
(
    input wire logic hclk,
    output logic cts_n,
    output logic dsr_n,
    output logic [5:0] rx_fill,
    output logic rx_valid,
    output logic [7:0] rx_char,
    input wire logic rx_store,
    input wire logic [7:0] ctl_char,
    input wire logic ctl_valid,
    output logic ctl_ready
);
    logic [7:0] sent_q[$];
    logic stored;
    initial
    begin
        cts_n = 1'b0;
        dsr_n = 1'b0;
        rx_fill = 6'h00;
        rx_valid = 1'b0;
        rx_char = 8'hA5;
        ctl_ready = 1'b0;
        stored = 1'b0;
    end
    // Ready drops after every taken character, so the sender always sees a stall.
    always @(posedge hclk)
    begin
        if (ctl_valid && ctl_ready)
            sent_q.push_back(ctl_char);
        ctl_ready <= ctl_valid && !ctl_ready;
    end
    // The data lines show the inverse once the pulse is over, so no stale value passes.
    task automatic send(input logic [7:0] c);
        rx_char <= c;
        rx_valid <= 1'b1;
        @(posedge hclk);
        stored = rx_store;
        rx_valid <= 1'b0;
        rx_char <= ~c;
        @(posedge hclk);
    endtask : send
endmodule : uefc_remote

/* sim/tb_top.sv */
// Register-level test sequence for the UART flow-control block.
`timescale 1ns/1ps
module tb_top
    import uefc_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rts_n, dtr_n, tx_hold;
    logic [7:0] haddr, interrupt_enable_reg, fifo_control_reg, msr_ctl, isr_enh, ctl_char, rx_char;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic cts_n, dsr_n, rx_valid, rx_store, ctl_valid, ctl_ready, rx_trig_irq;
    logic [5:0] rx_fill;
    int fails = 0;
    int cmp_count = 0;
    logic [7:0] exp_c;
    uefc_flow DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cts_n(cts_n), .dsr_n(dsr_n), .rts_n(rts_n), .dtr_n(dtr_n), .tx_hold(tx_hold),
        .rx_fill(rx_fill), .rx_valid(rx_valid), .rx_char(rx_char), .rx_store(rx_store),
        .ctl_char(ctl_char), .ctl_valid(ctl_valid), .ctl_ready(ctl_ready), .interrupt_enable_reg(interrupt_enable_reg),
        .fifo_control_reg(fifo_control_reg), .msr_ctl(msr_ctl), .rx_trig_irq(rx_trig_irq), .isr_enh(isr_enh));
    uefc_remote u_far (.hclk(hclk), .cts_n(cts_n), .dsr_n(dsr_n), .rx_fill(rx_fill),
        .rx_valid(rx_valid), .rx_char(rx_char), .rx_store(rx_store),
        .ctl_char(ctl_char), .ctl_valid(ctl_valid), .ctl_ready(ctl_ready));
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, {24'h000000, d}, q);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h00000000, q);
        chk($sformatf("reg %h", a), {24'h000000, e}, q);
    endtask : rd_chk
    initial
    begin
        #1000000;
        fails++;
        wrap_up();
    end
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        tick(6);
        hresetn <= 1'b1;
        tick(1);
        rd_chk(ADDR_EFC, 8'h00);
        rd_chk(ADDR_FCS, 8'h00);
        chk("rts_n", 32'h1, 32'(rts_n));
        chk("dtr_n", 32'h1, 32'(dtr_n));
        wr(ADDR_XON_CHAR_FIRST, 8'h11);
        rd_chk(ADDR_XON_CHAR_FIRST, 8'h00);
        rd_chk(8'h3C, 8'h00);
        wr(ADDR_IER, 8'hFF);
        tick(1);
        chk("ier", 32'h0, 32'(interrupt_enable_reg & MASK_IER));
        wr(ADDR_EFC, 8'h10);
        wr(ADDR_IER, 8'hFF);
        tick(1);
        chk("ier", 32'(MASK_IER), 32'(interrupt_enable_reg & MASK_IER));
        wr(ADDR_EFC, 8'h00);
        wr(ADDR_IER, 8'h00);
        tick(1);
        chk("ier", 32'(MASK_IER), 32'(interrupt_enable_reg & MASK_IER));
        wr(ADDR_FCR, 8'hFF);
        wr(ADDR_MSR, 8'hFF);
        tick(1);
        chk("fcr", 32'h0000_00CF, 32'(fifo_control_reg));
        chk("msr_ctl", 32'h0000_0003, 32'(msr_ctl));
        chk("hresp", 32'h0, 32'(hresp));
        wr(ADDR_EFC, 8'h90);
        for (int k = 0; k < 8; k++)
        begin
            wr(ADDR_MCR, {5'b00000, k[2], 2'b00});
            u_far.cts_n <= k[1];
            u_far.dsr_n <= k[0];
            tick(4);
            chk("tx_hold", 32'(k[2] ? k[0] : k[1]), 32'(tx_hold));
        end
        wr(ADDR_EFC, 8'h10);
        tick(2);
        chk("tx_hold", 32'h0, 32'(tx_hold));
        wr(ADDR_TRIG, 8'h42);
        for (int s = 0; s < 2; s++)
        begin
            wr(ADDR_EFC, 8'h50);
            wr(ADDR_MCR, s ? 8'h05 : 8'h02);
            u_far.rx_fill <= 6'd16;
            tick(3);
            chk("flow_out", 32'h1, 32'(s ? dtr_n : rts_n));
            chk("rx_trig_irq", 32'h1, 32'(rx_trig_irq));
            u_far.rx_fill <= 6'd10;
            tick(3);
            chk("flow_out", 32'h1, 32'(s ? dtr_n : rts_n));
            u_far.rx_fill <= 6'd3;
            tick(3);
            chk("flow_out", 32'h0, 32'(s ? dtr_n : rts_n));
        end
        wr(ADDR_EFC, 8'h10);
        wr(ADDR_MCR, 8'h02);
        u_far.rx_fill <= 6'd16;
        tick(3);
        chk("rts_n", 32'h0, 32'(rts_n));
        // A transfer without select must leave the trigger levels alone.
        haddr <= ADDR_TRIG;
        hwrite <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        tick(1);
        htrans <= 2'b00;
        hwdata <= 32'h0000_00FF;
        tick(1);
        rd_chk(ADDR_TRIG, 8'h42);
        wr(ADDR_XOFF_CHAR_SECOND, 8'h13);
        wr(ADDR_EFC, 8'h32);
        u_far.send(8'h13);
        chk("rx_store", 32'h1, 32'(u_far.stored));
        chk("isr_special", 32'h1, 32'(isr_enh[ISR_SPECIAL]));
        wr(ADDR_EFC, 8'h10);
        wr(ADDR_EFC, 8'h31);
        u_far.send(8'h13);
        chk("rx_store", 32'h0, 32'(u_far.stored));
        chk("isr_xoff", 32'h1, 32'(isr_enh[ISR_XOFF]));
        rd_chk(ADDR_FCS, 8'h01);
        rd_chk(ADDR_FCS, 8'h00);
        wr(ADDR_XON_CHAR_SECOND, 8'h22);
        wr(ADDR_XOFF_CHAR_FIRST, 8'h33);
        for (int m = 1; m < 4; m++)
        begin
            wr(ADDR_EFC, 8'h10);
            wr(ADDR_EFC, {4'h1, m[1:0], 2'b00});
            for (int c = 1; c >= 0; c--)
            begin
                u_far.sent_q.delete();
                wr(ADDR_TXCMD, {7'h00, c[0]});
                for (int n = 0; n < 40 && u_far.sent_q.size() < (m == 3 ? 2 : 1); n++)
                    tick(1);
                exp_c = m[1] ? (c ? 8'h11 : 8'h33) : (c ? 8'h22 : 8'h13);
                chk("tx_count", m == 3 ? 2 : 1, u_far.sent_q.size());
                chk("tx_char", 32'(exp_c), 32'(u_far.sent_q[0]));
                if (m == 3)
                    chk("tx_char2", c ? 32'h22 : 32'h13, 32'(u_far.sent_q[1]));
                rd_chk(ADDR_FCS, c ? 8'h08 : 8'h04);
            end
        end
        wr(ADDR_TXCMD, 8'h01);
        tick(10);
        wr(ADDR_EFC, 8'h10);
        rd_chk(ADDR_FCS, 8'h00);
        wr(ADDR_EFC, 8'h1B);
        u_far.send(8'h22);
        rd_chk(ADDR_FCS, 8'h02);
        u_far.send(8'h33);
        rd_chk(ADDR_FCS, 8'h01);
        wr(ADDR_EFC, 8'h10);
        wr(ADDR_EFC, 8'h1F);
        u_far.send(8'h11);
        rd_chk(ADDR_FCS, 8'h00);
        u_far.send(8'h11);
        u_far.send(8'h22);
        rd_chk(ADDR_FCS, 8'h02);
        // Reset in mid-run must clear interrupt_enable_reg, fifo_control_reg and msr_ctl and release rts_n.
        hresetn <= 1'b0;
        tick(2);
        chk("ier", 32'h0, 32'(interrupt_enable_reg));
        chk("fcr", 32'h0, 32'(fifo_control_reg));
        chk("msr_ctl", 32'h0, 32'(msr_ctl));
        chk("rts_n", 32'h1, 32'(rts_n));
        hresetn <= 1'b1;
        tick(1);
        rd_chk(ADDR_EFC, 8'h00);
        rd_chk(ADDR_MCR, 8'h00);
        wrap_up();
    end
endmodule : tb_top
